/* rtl/pwd_pkg.sv */
// shared constants and types for the program word and data bank addressing block
package pwd_pkg;
  localparam int PC_W = 21;
  localparam int DA_W = 12;
  localparam int RAM_BYTES = 3904;
  localparam logic [DA_W-1:0] RAM_TOP = DA_W'(RAM_BYTES);
  localparam logic [PC_W-1:0] PC_RST = 21'h0;
  localparam logic [PC_W-1:0] PC_STEP = 21'h2;
  localparam logic [3:0] SECOND_TAG = 4'hF;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam logic [DA_W-1:0] BANK_SFR_ADDR = 12'hFE0;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [7:0] OP_GOTO = 8'hEF;
  localparam logic [6:0] OP_CALL = 7'h76;
  localparam logic [7:0] OP_PTR_LOAD = 8'hEE;
  localparam logic [3:0] OP_MOVE = 4'hC;
  localparam logic [7:0] OP_BANK_LIT = 8'h01;
  localparam logic [4:0] OP_BRA = 5'h1A;
  localparam logic [4:0] OP_BCOND = 5'h1C;
  localparam logic [3:0] OP_FILE_LO = 4'h1;
  localparam logic [3:0] OP_FILE_HI = 4'hB;
  localparam logic [2:0] OP_MUL_FILE = 3'h1;
  localparam int ACC_BIT = 8;
  localparam logic [3:0] REG_BANK = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_PC = 4'hC;
  localparam int CTRL_USB_EN = 0;
  localparam logic CTRL_RST = 1'b0;
  typedef enum logic [1:0] {
    PWD_ST_FIRST = 2'b01,
    PWD_ST_SECOND = 2'b10
  } pwd_state_t;
  typedef enum logic [3:0] {
    PWD_K_NONE = 4'h0,
    PWD_K_NOP = 4'h1,
    PWD_K_FILE = 4'h2,
    PWD_K_GOTO = 4'h3,
    PWD_K_CALL = 4'h4,
    PWD_K_MOVE = 4'h5,
    PWD_K_PTR_LOAD = 4'h6,
    PWD_K_BANK_LIT = 4'h7,
    PWD_K_BRA = 4'h8,
    PWD_K_BCOND = 4'h9,
    PWD_K_OTHER = 4'hA
  } pwd_kind_t;
  typedef struct packed {
    logic valid;
    pwd_kind_t kind;
    logic [DA_W-1:0] addr;
    logic [7:0] rdata;
    logic [DA_W-1:0] literal;
    logic [1:0] ptr_sel;
  } pwd_exec_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [DA_W-1:0] addr;
    logic [7:0] wdata;
  } pwd_usb_req_t;
endpackage : pwd_pkg

/* rtl/pwd_core.sv */
// instruction word decoder, program counter and banked dual access data memory
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module pwd_core (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_word_in,
  input wire logic skip_next_in,
  input wire logic branch_cond_in,
  input wire logic alu_wr_in,
  input wire logic [7:0] alu_wdata_in,
  output logic [pwd_pkg::PC_W-1:0] pc_out,
  output pwd_pkg::pwd_exec_t exec_out,
  input wire pwd_pkg::pwd_usb_req_t usb_req_in,
  output logic usb_ready_out,
  output logic [7:0] usb_rdata_out,
  output logic usb_rvalid_out
);
  logic [7:0] ram_mem [0:pwd_pkg::RAM_BYTES-1];
  pwd_pkg::pwd_state_t state_reg;
  pwd_pkg::pwd_state_t state_next;
  pwd_pkg::pwd_exec_t exec_reg;
  pwd_pkg::pwd_exec_t exec_next;
  logic [pwd_pkg::PC_W-1:0] pc_reg;
  logic [pwd_pkg::PC_W-1:0] pc_next;
  logic [15:0] first_reg;
  logic [3:0] bank_reg;
  logic usb_en_reg;
  logic skip_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0] usb_rdata_reg;
  logic usb_rvalid_reg;
  logic [15:0] w;
  logic is_goto;
  logic is_call;
  logic is_move;
  logic is_ptr;
  logic is_two;
  logic is_lit;
  logic is_bra;
  logic is_bc;
  logic is_tag;
  logic is_file;
  logic [pwd_pkg::DA_W-1:0] file_addr;
  logic [pwd_pkg::DA_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic core_wr;
  logic [pwd_pkg::DA_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic move_wr;
  logic lit_wr;
  logic usb_go;
  logic bus_req;
  logic bus_wr;
  logic [pwd_pkg::PC_W-1:0] pc_seq;

  assign w = instr_word_in;
  assign pc_seq = pc_reg + pwd_pkg::PC_STEP;

  // first word classification
  always_comb begin
    is_goto = (w[15:8] == pwd_pkg::OP_GOTO);
    is_call = (w[15:9] == pwd_pkg::OP_CALL);
    is_move = (w[15:12] == pwd_pkg::OP_MOVE);
    is_ptr = (w[15:8] == pwd_pkg::OP_PTR_LOAD) && (w[7:6] == 2'h0);
    is_two = is_goto | is_call | is_move | is_ptr;
    is_lit = (w[15:8] == pwd_pkg::OP_BANK_LIT) && (w[7:4] == 4'h0);
    is_bra = (w[15:11] == pwd_pkg::OP_BRA);
    is_bc = (w[15:11] == pwd_pkg::OP_BCOND);
    is_tag = (w[15:12] == pwd_pkg::SECOND_TAG);
    is_file = ((w[15:12] >= pwd_pkg::OP_FILE_LO) && (w[15:12] <= pwd_pkg::OP_FILE_HI))
      || ((w[15:12] == 4'h0) && (w[11:9] == pwd_pkg::OP_MUL_FILE));
  end

  // eight-bit operand to twelve-bit address
  always_comb begin
    if (w[pwd_pkg::ACC_BIT]) begin
      file_addr = {bank_reg, w[7:0]};
    end else if (w[7:0] < pwd_pkg::ACC_SPLIT) begin
      file_addr = {pwd_pkg::ACC_LO_BANK, w[7:0]};
    end else begin
      file_addr = {pwd_pkg::ACC_HI_BANK, w[7:0]};
    end
  end

  // decode, execute and next program counter
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    exec_next = exec_reg;
    exec_next.valid = 1'b0;
    move_wr = 1'b0;
    lit_wr = 1'b0;
    if (instr_valid_in) begin
      pc_next = pc_seq;
      exec_next.valid = 1'b1;
      exec_next.kind = pwd_pkg::PWD_K_OTHER;
      exec_next.addr = '0;
      exec_next.literal = '0;
      exec_next.ptr_sel = 2'h0;
      case (state_reg)
        pwd_pkg::PWD_ST_FIRST: begin
          if (skip_reg || is_tag) begin
            exec_next.kind = pwd_pkg::PWD_K_NOP;
          end else if (is_two) begin
            state_next = pwd_pkg::PWD_ST_SECOND;
            exec_next.valid = 1'b0;
          end else if (is_lit) begin
            exec_next.kind = pwd_pkg::PWD_K_BANK_LIT;
            exec_next.literal = {8'h00, w[3:0]};
            lit_wr = 1'b1;
          end else if (is_bra) begin
            exec_next.kind = pwd_pkg::PWD_K_BRA;
            pc_next = pc_seq + {{9{w[10]}}, w[10:0], 1'b0};
          end else if (is_bc) begin
            exec_next.kind = pwd_pkg::PWD_K_BCOND;
            if (branch_cond_in) begin
              pc_next = pc_seq + {{12{w[7]}}, w[7:0], 1'b0};
            end
          end else if (is_file) begin
            exec_next.kind = pwd_pkg::PWD_K_FILE;
            exec_next.addr = file_addr;
          end
        end
        pwd_pkg::PWD_ST_SECOND: begin
          state_next = pwd_pkg::PWD_ST_FIRST;
          if (!is_tag) begin
            exec_next.kind = pwd_pkg::PWD_K_NOP;
          end else if (first_reg[15:12] == pwd_pkg::OP_MOVE) begin
            exec_next.kind = pwd_pkg::PWD_K_MOVE;
            exec_next.addr = w[11:0];
            move_wr = 1'b1;
          end else if (first_reg[15:8] == pwd_pkg::OP_PTR_LOAD) begin
            exec_next.kind = pwd_pkg::PWD_K_PTR_LOAD;
            exec_next.ptr_sel = first_reg[5:4];
            exec_next.literal = {first_reg[3:0], w[7:0]};
          end else begin
            exec_next.kind = (first_reg[15:8] == pwd_pkg::OP_GOTO) ? pwd_pkg::PWD_K_GOTO : pwd_pkg::PWD_K_CALL;
            exec_next.literal = w[11:0];
            pc_next = {w[11:0], first_reg[7:0], 1'b0};
          end
        end
        default: begin
          state_next = pwd_pkg::PWD_ST_FIRST;
        end
      endcase
      exec_next.rdata = rd_data;
    end
  end

  // core read address: full move source or mapped operand
  always_comb begin
    if (instr_valid_in && (state_reg == pwd_pkg::PWD_ST_SECOND) && is_tag
        && (first_reg[15:12] == pwd_pkg::OP_MOVE)) begin
      rd_addr = first_reg[11:0];
    end else begin
      rd_addr = file_addr;
    end
  end

  // core read mux over ram, bank pointer and empty space
  always_comb begin
    if (rd_addr < pwd_pkg::RAM_TOP) begin
      rd_data = ram_mem[rd_addr];
    end else if (rd_addr == pwd_pkg::BANK_SFR_ADDR) begin
      rd_data = {4'h0, bank_reg};
    end else begin
      rd_data = 8'h00;
    end
  end

  // core write source: the move beats a late alu write-back
  always_comb begin
    core_wr = move_wr | alu_wr_in;
    if (move_wr) begin
      wr_addr = exec_next.addr;
      wr_data = rd_data;
    end else begin
      wr_addr = exec_reg.addr;
      wr_data = alu_wdata_in;
    end
  end

  // usb engine waits while the core writes
  assign usb_go = usb_req_in.req && usb_en_reg && !core_wr;
  assign usb_ready_out = usb_en_reg && !core_wr;

  always_ff @(posedge clk_in) begin
    if (core_wr && (wr_addr < pwd_pkg::RAM_TOP)) begin
      ram_mem[wr_addr] <= wr_data;
    end else if (usb_go && usb_req_in.we && (usb_req_in.addr < pwd_pkg::RAM_TOP)) begin
      ram_mem[usb_req_in.addr] <= usb_req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      usb_rdata_reg <= 8'h00;
      usb_rvalid_reg <= 1'b0;
    end else begin
      usb_rvalid_reg <= usb_go && !usb_req_in.we;
      if (usb_go && !usb_req_in.we) begin
        usb_rdata_reg <= (usb_req_in.addr < pwd_pkg::RAM_TOP) ? ram_mem[usb_req_in.addr] : 8'h00;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= pwd_pkg::PWD_ST_FIRST;
      first_reg <= 16'h0000;
      pc_reg <= pwd_pkg::PC_RST;
      exec_reg <= '0;
    end else begin
      state_reg <= state_next;
      pc_reg <= {pc_next[pwd_pkg::PC_W-1:1], 1'b0};
      exec_reg <= exec_next;
      if (instr_valid_in && (state_reg == pwd_pkg::PWD_ST_FIRST)) begin
        first_reg <= w;
      end
    end
  end

  // skip request squashes the next first word taken
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      skip_reg <= 1'b0;
    end else if (skip_next_in) begin
      skip_reg <= 1'b1;
    end else if (instr_valid_in && (state_reg == pwd_pkg::PWD_ST_FIRST)) begin
      skip_reg <= 1'b0;
    end
  end

  // avalon slave: one wait cycle on every access
  assign bus_req = avs_read_in | avs_write_in;
  assign bus_wr = avs_write_in && ack_reg && avs_byteenable_in[0];
  assign avs_waitrequest_out = bus_req && !ack_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      if (avs_read_in && !ack_reg) begin
        case (avs_address_in)
          pwd_pkg::REG_BANK: rdata_reg <= {28'h0000000, bank_reg};
          pwd_pkg::REG_CTRL: rdata_reg <= {31'h0, usb_en_reg};
          pwd_pkg::REG_STAT: rdata_reg <= {28'h0000000, skip_reg, state_reg, usb_en_reg};
          pwd_pkg::REG_PC: rdata_reg <= {11'h0, pc_reg};
          default: rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // bank pointer: instruction, then core store, then bus
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bank_reg <= pwd_pkg::BANK_RST;
    end else if (lit_wr) begin
      bank_reg <= w[3:0];
    end else if (core_wr && (wr_addr == pwd_pkg::BANK_SFR_ADDR)) begin
      bank_reg <= wr_data[3:0];
    end else if (bus_wr && (avs_address_in == pwd_pkg::REG_BANK)) begin
      bank_reg <= avs_writedata_in[3:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      usb_en_reg <= pwd_pkg::CTRL_RST;
    end else if (bus_wr && (avs_address_in == pwd_pkg::REG_CTRL)) begin
      usb_en_reg <= avs_writedata_in[pwd_pkg::CTRL_USB_EN];
    end
  end

  assign avs_readdata_out = rdata_reg;
  assign pc_out = pc_reg;
  assign exec_out = exec_reg;
  assign usb_rdata_out = usb_rdata_reg;
  assign usb_rvalid_out = usb_rvalid_reg;
endmodule : pwd_core
`default_nettype wire

/* bench/pwd_usb_model.sv */
// usb engine stand-in driving the shared ram port
`timescale 1ns/1ns
`default_nettype none
module pwd_usb_model (
  input wire logic clk_in,
  input wire logic ready_in,
  input wire logic [7:0] rdata_in,
  output var pwd_pkg::pwd_usb_req_t req_out
);
  initial req_out = '0;
  task xfer(input logic we, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    req_out <= '{1'h1, we, a, d};
    do @(posedge clk_in); while (!ready_in);
    req_out <= '{1'h0, ~we, ~a, ~d};
    @(posedge clk_in);
    q = rdata_in;
  endtask : xfer
endmodule : pwd_usb_model
`default_nettype wire

/* bench/pwd_core_sva.sv */
// port assertions for the addressing core
`timescale 1ns/1ns
`default_nettype none
module pwd_core_sva (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_word_in,
  input wire logic [pwd_pkg::PC_W-1:0] pc_out,
  input wire pwd_pkg::pwd_exec_t exec_out,
  input wire pwd_pkg::pwd_usb_req_t usb_req_in,
  input wire logic usb_ready_out,
  input wire logic usb_rvalid_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence goto_pair;
    instr_valid_in && instr_word_in[15:8] == pwd_pkg::OP_GOTO ##1
    instr_valid_in && instr_word_in[15:12] == pwd_pkg::SECOND_TAG;
  endsequence
  sequence move_pair;
    instr_valid_in && instr_word_in[15:12] == pwd_pkg::OP_MOVE ##1
    instr_valid_in && instr_word_in[15:12] == pwd_pkg::SECOND_TAG;
  endsequence
  pc_even_a: assert property (pc_out[0] == 1'h0) else $error("pc odd");
  wait_one_a: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("wait long");
  goto_pc_a: assert property (goto_pair |=>
    pc_out == {$past(instr_word_in[11:0]), $past(instr_word_in[7:0], 2), 1'h0}) else $error("goto pc");
  bra_pc_a: assert property (instr_valid_in && instr_word_in[15:11] == pwd_pkg::OP_BRA |=>
    pc_out == $past(pc_out) + 21'h2 + {{9{$past(instr_word_in[10])}}, $past(instr_word_in[10:0]), 1'h0})
    else $error("bra pc");
  move_addr_a: assert property (move_pair |=>
    exec_out.kind != pwd_pkg::PWD_K_MOVE || exec_out.addr == $past(instr_word_in[11:0])) else $error("move");
  bank_lit_a: assert property (instr_valid_in && instr_word_in[15:8] == pwd_pkg::OP_BANK_LIT
    && instr_word_in[7:4] == 4'h0 |=>
    exec_out.valid && exec_out.kind == pwd_pkg::PWD_K_BANK_LIT) else $error("bank literal");
  acc_map_a: assert property (instr_valid_in && instr_word_in[15:12] == 4'h5 && !instr_word_in[8] |=>
    exec_out.addr == {($past(instr_word_in[7:0]) < pwd_pkg::ACC_SPLIT) ? 4'h0 : 4'hF, $past(instr_word_in[7:0])})
    else $error("quick bank");
  usb_rd_a: assert property (usb_req_in.req && !usb_req_in.we && usb_ready_out |=> usb_rvalid_out)
    else $error("usb read");
  rv_cause_a: assert property (usb_rvalid_out |-> $past(usb_req_in.req && !usb_req_in.we && usb_ready_out))
    else $error("stray rvalid");
endmodule : pwd_core_sva
bind pwd_core pwd_core_sva pwd_core_sva_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .instr_valid_in(instr_valid_in),
  .instr_word_in(instr_word_in), .pc_out(pc_out), .exec_out(exec_out), .usb_req_in(usb_req_in),
  .usb_ready_out(usb_ready_out), .usb_rvalid_out(usb_rvalid_out));
`default_nettype wire

/* bench/pwd_core_test.sv */
// self-checking bench for the addressing core
`timescale 1ns/1ns
`default_nettype none
module pwd_core_test;
  logic clk_in, rst_n_in, avs_read_in, avs_write_in, instr_valid_in, skip_next_in, branch_cond_in, alu_wr_in;
  logic avs_waitrequest_out, usb_ready_out, usb_rvalid_out;
  logic [3:0] avs_address_in, avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, r;
  logic [15:0] instr_word_in;
  logic [7:0] alu_wdata_in, usb_rdata_out, q;
  logic [pwd_pkg::PC_W-1:0] pc_out;
  pwd_pkg::pwd_exec_t exec_out;
  pwd_pkg::pwd_usb_req_t usb_req_in;
  int mismatches, checks;
  pwd_core pwd_core_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
    .skip_next_in(skip_next_in), .branch_cond_in(branch_cond_in), .alu_wr_in(alu_wr_in),
    .alu_wdata_in(alu_wdata_in), .pc_out(pc_out), .exec_out(exec_out), .usb_req_in(usb_req_in),
    .usb_ready_out(usb_ready_out), .usb_rdata_out(usb_rdata_out), .usb_rvalid_out(usb_rvalid_out));
  pwd_usb_model pwd_usb_model_inst (.clk_in(clk_in), .ready_in(usb_ready_out), .rdata_in(usb_rdata_out),
    .req_out(usb_req_in));
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task results;
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge clk_in); while (avs_waitrequest_out);
    r = avs_readdata_out;
    avs_read_in <= 1'h0;
    avs_write_in <= 1'h0;
  endtask : bus
  task rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(r, e);
  endtask : rd
  task prog(input int n, input logic [15:0] a, input logic [15:0] b, input logic c);
    @(posedge clk_in);
    instr_valid_in <= 1'h1;
    instr_word_in <= a;
    branch_cond_in <= c;
    if (n == 2) begin
      @(posedge clk_in);
      instr_word_in <= b;
    end
    @(posedge clk_in);
    instr_valid_in <= 1'h0;
    @(negedge clk_in);
  endtask : prog
  task alu_st(input logic [7:0] d);
    @(posedge clk_in);
    alu_wr_in <= 1'h1;
    alu_wdata_in <= d;
    @(posedge clk_in);
    alu_wr_in <= 1'h0;
  endtask : alu_st
  task t_regs;
    rd(4'h0, 32'h0);
    bus(1'h1, 4'h0, 32'hFFFFFFFA);
    rd(4'h0, 32'hA);
    avs_byteenable_in <= 4'hE;
    bus(1'h1, 4'h0, 32'h5);
    avs_byteenable_in <= 4'hF;
    rd(4'h0, 32'hA);
    rd(4'h2, 32'h0);
    rd(4'h8, 32'h2);
  endtask : t_regs
  task t_jump;
    prog(2, 16'hEF03, 16'hF000, 1'h0);
    chk(pc_out, 21'h6);
    chk(exec_out.kind, pwd_pkg::PWD_K_GOTO);
    prog(2, 16'hEC05, 16'hF001, 1'h0);
    chk(pc_out, 21'h20A);
    chk(exec_out.kind, pwd_pkg::PWD_K_CALL);
    chk(exec_out.literal, 12'h001);
    prog(1, 16'hD7FE, 16'h0, 1'h0);
    chk(pc_out, 21'h208);
    prog(1, 16'hE003, 16'h0, 1'h1);
    chk(pc_out, 21'h210);
    prog(1, 16'hE003, 16'h0, 1'h0);
    rd(4'hC, 32'h212);
  endtask : t_jump
  task t_lone;
    prog(1, 16'hF123, 16'h0, 1'h0);
    chk(exec_out.kind, pwd_pkg::PWD_K_NOP);
    @(posedge clk_in);
    skip_next_in <= 1'h1;
    @(posedge clk_in);
    skip_next_in <= 1'h0;
    prog(2, 16'hC123, 16'hF456, 1'h0);
    chk(exec_out.kind, pwd_pkg::PWD_K_NOP);
    chk(pc_out, 21'h218);
    prog(2, 16'hEE15, 16'hF0AB, 1'h0);
    chk(exec_out.kind, pwd_pkg::PWD_K_PTR_LOAD);
    chk(exec_out.literal, 12'h5AB);
    chk(exec_out.ptr_sel, 2'h1);
    chk(pc_out, 21'h21C);
  endtask : t_lone
  task t_data;
    chk(usb_ready_out, 1'h0);
    bus(1'h1, 4'h4, 32'h1);
    rd(4'h8, 32'h3);
    pwd_usb_model_inst.xfer(1'h1, 12'h123, 8'hA5, q);
    pwd_usb_model_inst.xfer(1'h1, 12'hF3F, 8'h3C, q);
    pwd_usb_model_inst.xfer(1'h1, 12'hF40, 8'h99, q);
    pwd_usb_model_inst.xfer(1'h0, 12'hF3F, 8'h0, q);
    chk(q, 8'h3C);
    pwd_usb_model_inst.xfer(1'h0, 12'hF40, 8'h0, q);
    chk(q, 8'h00);
    // bank 1 reads back the byte the usb engine wrote at 0x123
    prog(1, 16'h0101, 16'h0, 1'h0);
    rd(4'h0, 32'h1);
    prog(1, 16'h5323, 16'h0, 1'h0);
    chk(exec_out.addr, 12'h123);
    chk(exec_out.rdata, 8'hA5);
    prog(2, 16'hC123, 16'hF456, 1'h0);
    chk(exec_out.addr, 12'h456);
    pwd_usb_model_inst.xfer(1'h0, 12'h456, 8'h0, q);
    chk(q, 8'hA5);
    prog(1, 16'h5210, 16'h0, 1'h0);
    chk(exec_out.addr, 12'h010);
    prog(1, 16'h52F0, 16'h0, 1'h0);
    chk(exec_out.addr, 12'hFF0);
    prog(1, 16'h010F, 16'h0, 1'h0);
    prog(1, 16'h5350, 16'h0, 1'h0);
    chk(exec_out.rdata, 8'h0);
    chk(exec_out.valid, 1'h1);
    alu_st(8'h77);
    prog(1, 16'h5350, 16'h0, 1'h0);
    chk(exec_out.rdata, 8'h0);
    prog(1, 16'h51E0, 16'h0, 1'h0);
    chk(exec_out.addr, 12'hFE0);
    chk(exec_out.rdata, 8'h0F);
    alu_st(8'hA3);
    rd(4'h0, 32'h3);
  endtask : t_data
  task t_reset;
    @(posedge clk_in);
    rst_n_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'h1;
    rd(4'h0, 32'h0);
    chk(pc_out, 21'h0);
  endtask : t_reset
  initial begin
    {rst_n_in, avs_read_in, avs_write_in, instr_valid_in, skip_next_in, branch_cond_in, alu_wr_in} = '0;
    avs_address_in = 4'h0;
    avs_byteenable_in = 4'hF;
    avs_writedata_in = 32'h0;
    instr_word_in = 16'h0;
    alu_wdata_in = 8'h0;
    mismatches = 0;
    checks = 0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'h1;
    t_regs;
    t_jump;
    t_lone;
    t_data;
    t_reset;
    results;
  end
  initial begin
    #1000000;
    mismatches++;
    results;
  end
endmodule : pwd_core_test
`default_nettype wire
